// ===== rtl/hev_pkg.sv
// constants, types and register map of the channel interrupt event sources
//
// Overview of operation
// - interrupt mode: block-full after 32 unfinished frame bytes
// - interrupt mode: message-end after CRC and closing flag
// - DMA mode: message-end once DMA read everything
// - frame-overflow on new frame with full receive FIFO
// - frame-start only when receive-start enable set
// - frame-start two bytes after address match/opening flag
// - control, address, status bits valid at frame-start
// - pool-ready on free transmit half, also after reset command
// - interrupt mode: pool-ready repeats until end-of-message command
// - after end-of-message: pool-ready when transparent frame done (interrupt mode only, none in DMA mode)
// - auto mode: pool-ready on positive acknowledge
// - auto mode: message-repeat on negative acknowledge
// - bus configuration: collision after 32nd byte repeats
// - point-to-point: clear-to-send lost after 32nd byte repeats
// - underrun when all shifted without end-of-message
// - interrupt mode: end-of-message command marks message end
// - DMA mode: end-of-message from preset byte count
// - interrupt output low until status reads clear
// - mask bits suppress primary status bits individually
// - interrupt mode after reset; DMA bit selects DMA
package hev_pkg;

  // register offsets on the 4-bit register port
  localparam logic [3:0] OFS_PRIMARY = 4'h0;
  localparam logic [3:0] OFS_EXTENDED = 4'h1;
  localparam logic [3:0] OFS_MASK = 4'h2;
  localparam logic [3:0] OFS_CFG2 = 4'h3;
  localparam logic [3:0] OFS_COMMAND = 4'h4;
  localparam logic [3:0] OFS_CNT_HIGH = 4'h5;
  localparam logic [3:0] OFS_CNT_LOW = 4'h6;
  localparam logic [3:0] OFS_RX_CTRL = 4'h7;
  localparam logic [3:0] OFS_RX_ADDR = 4'h8;
  localparam logic [3:0] OFS_RX_STAT = 4'h9;
  localparam logic [3:0] OFS_MODE = 4'hA;

  // primary status bits
  localparam int PRI_BLOCK_FULL = 0;
  localparam int PRI_MSG_END = 1;
  localparam int PRI_POOL_READY = 2;
  // extended status bits
  localparam int EXT_OVERFLOW = 0;
  localparam int EXT_FRAME_START = 1;
  localparam int EXT_REPEAT = 2;
  localparam int EXT_UNDERRUN = 3;
  // mask bit that gates the whole extended register
  localparam int MASK_EXT = 3;
  // command bits
  localparam int CMD_TX_RESET = 0;
  localparam int CMD_TX_TRANSP = 1;
  localparam int CMD_TX_INFO = 2;
  localparam int CMD_TX_MSG_END = 3;
  // configuration bits
  localparam int CFG2_RX_START_EN = 0;
  localparam int CNTH_DMA = 7;
  localparam int MODE_AUTO = 0;
  localparam int MODE_BUS = 1;
  localparam int MODE_ADDR_RECOG = 2;

  // reset values
  localparam logic [3:0] MASK_RESET = 4'h0;
  localparam logic [2:0] MODE_RESET = 3'h0;

  // byte counts
  localparam logic [5:0] RX_BLOCK_BYTES = 6'h20;
  localparam logic [11:0] TX_REPEAT_BYTES = 12'h020;
  localparam logic [1:0] RFS_DELAY_BYTES = 2'h2;

  // transmit sequence states
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_OPEN = 2'b01,
    TX_CLOSED = 2'b10
  } hev_txst_type;

endpackage

// ===== rtl/hev_event_sources.sv
// interrupt event sources of one serial channel with register port
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module hev_event_sources (
  input wire logic mclk,
  input wire logic rst,
  // register port, read data one cycle after the strobe
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  // receive datapath events, same clock
  input wire logic rxByteStored,
  input wire logic rxFrameBegin,
  input wire logic rxFrameEnd,
  input wire logic rxFifoFull,
  input wire logic rxAddrMatch,
  input wire logic rxOpenFlag,
  input wire logic dmaRxRead,
  input wire logic [7:0] rxCtrlIn,
  input wire logic [7:0] rxAddrIn,
  input wire logic [3:0] rxStatIn,
  // transmit datapath events, same clock
  input wire logic txPoolFree,
  input wire logic txByteShifted,
  input wire logic txFrameDone,
  input wire logic txAllShifted,
  input wire logic txPosAck,
  input wire logic txNegAck,
  input wire logic txCollision,
  // clear-to-send pin, asynchronous
  input wire logic ctsN,
  // outputs
  output logic irqN,
  output logic txEom
);

  ////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [1:0] ctsSync; // pin synchroniser
    logic ctsPrev; // for withdrawal edge
    logic [2:0] prim; // primary status
    logic [3:0] ext; // extended status
    logic [3:0] mask; // interrupt mask
    logic rxStartEn; // frame-start enable
    logic dmaMode; // transfer mode
    logic [3:0] cntHigh; // preset count high
    logic [7:0] cntLow; // preset count low
    logic [2:0] mode; // auto/bus/address recog
    logic [7:0] rxCtrl; // received control byte
    logic [7:0] rxAddr; // received address low
    logic [3:0] rxStat; // receive status low bits
    logic [5:0] rxBlk; // bytes in current block
    logic rfsArm; // frame-start delay running
    logic [1:0] rfsCnt; // delay bytes seen
    logic [11:0] rxPend; // stored, not yet read by DMA
    logic rxEndPend; // DMA message-end waiting
    hev_pkg::hev_txst_type txState; // transmit sequence
    logic txTransp; // transparent frame running
    logic [11:0] txSent; // data bytes shifted out
    logic eom; // end-of-message known
    logic [7:0] rdata; // read data
    logic irqN; // interrupt pin
  } hev_state_type;

  hev_state_type s_reg;
  hev_state_type s_next;

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [2:0] primSet;
    logic [3:0] extSet;
    logic [11:0] txCount;
    logic ctsLost;
    logic writeCmd;
    primSet = 3'h0;
    extSet = 4'h0;
    txCount = {s_reg.cntHigh, s_reg.cntLow};
    s_next = s_reg;
    // first stage only feeds the second
    s_next.ctsSync = {s_reg.ctsSync[0], ctsN};
    s_next.ctsPrev = s_reg.ctsSync[1];
    // withdrawal is the rising edge of the active-low pin
    ctsLost = s_reg.ctsSync[1] && !s_reg.ctsPrev;
    writeCmd = regWrite && (regAddr == hev_pkg::OFS_COMMAND);

    // receive block counting
    if (rxFrameEnd) begin
      s_next.rxBlk = 6'h00;
    end else if (rxByteStored) begin
      if (s_reg.rxBlk + 6'h01 == hev_pkg::RX_BLOCK_BYTES) begin
        s_next.rxBlk = 6'h00;
        // frame still open, a full block waits
        if (!s_reg.dmaMode) begin
          primSet[hev_pkg::PRI_BLOCK_FULL] = 1'b1;
        end
      end else begin
        s_next.rxBlk = s_reg.rxBlk + 6'h01;
      end
    end

    // receive message end
    if (rxFrameEnd && !s_reg.dmaMode) begin
      primSet[hev_pkg::PRI_MSG_END] = 1'b1;
    end
    // outstanding bytes for DMA drain
    // in interrupt mode the CPU drains the fifo, so those bytes must not count,
    // else a stale total would hold off the DMA message-end forever
    case ({rxByteStored && s_reg.dmaMode, dmaRxRead && s_reg.dmaMode})
      2'b10: s_next.rxPend = s_reg.rxPend + 12'h001;
      2'b01: s_next.rxPend = s_reg.rxPend - 12'h001;
      default: s_next.rxPend = s_reg.rxPend;
    endcase
    if (rxFrameEnd && s_reg.dmaMode) begin
      s_next.rxEndPend = 1'b1;
    end
    // fire only once the DMA has emptied what was stored
    if (s_reg.rxEndPend && s_reg.rxPend == 12'h000) begin
      primSet[hev_pkg::PRI_MSG_END] = 1'b1;
      s_next.rxEndPend = rxFrameEnd && s_reg.dmaMode;
    end

    // frame overflow
    if (rxFrameBegin && rxFifoFull) begin
      extSet[hev_pkg::EXT_OVERFLOW] = 1'b1;
    end

    // frame start, delayed by two bytes
    if (s_reg.mode[hev_pkg::MODE_ADDR_RECOG] ? rxAddrMatch : rxOpenFlag) begin
      s_next.rfsArm = 1'b1;
      s_next.rfsCnt = 2'h0;
    end else if (s_reg.rfsArm && rxByteStored) begin
      if (s_reg.rfsCnt + 2'h1 == hev_pkg::RFS_DELAY_BYTES) begin
        s_next.rfsArm = 1'b0;
        // captured fields are valid by the time the flag shows
        s_next.rxCtrl = rxCtrlIn;
        s_next.rxAddr = rxAddrIn;
        s_next.rxStat = rxStatIn;
        if (s_reg.rxStartEn) begin
          extSet[hev_pkg::EXT_FRAME_START] = 1'b1;
        end
      end else begin
        s_next.rfsCnt = s_reg.rfsCnt + 2'h1;
      end
    end

    // transmit byte count and DMA end-of-message
    if (txByteShifted) begin
      s_next.txSent = s_reg.txSent + 12'h001;
      if (s_reg.dmaMode && s_reg.txSent + 12'h001 == txCount) begin
        s_next.eom = 1'b1;
        s_next.txState = hev_pkg::TX_CLOSED;
      end
    end

    // pool ready from a freed transmit half
    if (txPoolFree) begin
      if (s_reg.dmaMode || s_reg.txState != hev_pkg::TX_CLOSED) begin
        primSet[hev_pkg::PRI_POOL_READY] = 1'b1;
      end
    end

    // transparent frame fully out after end-of-message
    if (txFrameDone) begin
      if (!s_reg.dmaMode && s_reg.txState == hev_pkg::TX_CLOSED && s_reg.txTransp) begin
        primSet[hev_pkg::PRI_POOL_READY] = 1'b1;
      end
      if (!s_reg.mode[hev_pkg::MODE_AUTO] || s_reg.txTransp) begin
        s_next.txState = hev_pkg::TX_IDLE;
      end
    end

    // auto mode acknowledges
    if (s_reg.mode[hev_pkg::MODE_AUTO]) begin
      if (txPosAck) begin
        primSet[hev_pkg::PRI_POOL_READY] = 1'b1;
        s_next.txState = hev_pkg::TX_IDLE;
      end
      if (txNegAck) begin
        extSet[hev_pkg::EXT_REPEAT] = 1'b1;
      end
    end

    // late collision or lost clear-to-send
    // below 32 bytes the frame is simply restarted, no event
    if (s_reg.txSent >= hev_pkg::TX_REPEAT_BYTES) begin
      if (s_reg.mode[hev_pkg::MODE_BUS] && txCollision) begin
        extSet[hev_pkg::EXT_REPEAT] = 1'b1;
      end
      if (!s_reg.mode[hev_pkg::MODE_BUS] && ctsLost) begin
        extSet[hev_pkg::EXT_REPEAT] = 1'b1;
      end
    end

    // underrun: shifter drained with no end known
    // an idle or closed transmitter cannot starve
    if (txAllShifted && !s_reg.eom && s_reg.txState == hev_pkg::TX_OPEN) begin
      extSet[hev_pkg::EXT_UNDERRUN] = 1'b1;
      s_next.txState = hev_pkg::TX_IDLE;
    end

    // commands; a command wins over datapath events this cycle
    if (writeCmd) begin
      if (regWdata[hev_pkg::CMD_TX_TRANSP] || regWdata[hev_pkg::CMD_TX_INFO]) begin
        s_next.txState = hev_pkg::TX_OPEN;
        s_next.txTransp = regWdata[hev_pkg::CMD_TX_TRANSP];
        s_next.txSent = 12'h000;
        s_next.eom = 1'b0;
      end
      // in DMA mode the count decides, not the command
      if (regWdata[hev_pkg::CMD_TX_MSG_END] && !s_reg.dmaMode) begin
        s_next.eom = 1'b1;
        s_next.txState = hev_pkg::TX_CLOSED;
      end
      // reset last, so it overrides an open in the same write
      if (regWdata[hev_pkg::CMD_TX_RESET]) begin
        s_next.txState = hev_pkg::TX_IDLE;
        s_next.txSent = 12'h000;
        s_next.eom = 1'b0;
        primSet[hev_pkg::PRI_POOL_READY] = 1'b1;
      end
    end

    // configuration writes
    // the DMA bit shares the count high register with the count
    if (regWrite) begin
      case (regAddr)
        hev_pkg::OFS_MASK: s_next.mask = regWdata[3:0];
        hev_pkg::OFS_CFG2: s_next.rxStartEn = regWdata[hev_pkg::CFG2_RX_START_EN];
        hev_pkg::OFS_CNT_HIGH: begin
          s_next.dmaMode = regWdata[hev_pkg::CNTH_DMA];
          s_next.cntHigh = regWdata[3:0];
        end
        hev_pkg::OFS_CNT_LOW: s_next.cntLow = regWdata;
        hev_pkg::OFS_MODE: s_next.mode = regWdata[2:0];
        default: s_next.cntLow = s_next.cntLow; // no other writable register
      endcase
    end

    // read data and read-to-clear; a same-cycle event survives
    // only the two status registers change on a read
    s_next.rdata = 8'h00;
    s_next.prim = s_reg.prim | primSet;
    s_next.ext = s_reg.ext | extSet;
    if (regRead) begin
      case (regAddr)
        hev_pkg::OFS_PRIMARY: begin
          s_next.rdata = {5'h00, s_reg.prim};
          s_next.prim = primSet;
        end
        hev_pkg::OFS_EXTENDED: begin
          s_next.rdata = {4'h0, s_reg.ext};
          s_next.ext = extSet;
        end
        hev_pkg::OFS_MASK: s_next.rdata = {4'h0, s_reg.mask};
        hev_pkg::OFS_CFG2: s_next.rdata = {7'h00, s_reg.rxStartEn};
        hev_pkg::OFS_CNT_HIGH: s_next.rdata = {s_reg.dmaMode, 3'h0, s_reg.cntHigh};
        hev_pkg::OFS_CNT_LOW: s_next.rdata = s_reg.cntLow;
        hev_pkg::OFS_RX_CTRL: s_next.rdata = s_reg.rxCtrl;
        hev_pkg::OFS_RX_ADDR: s_next.rdata = s_reg.rxAddr;
        hev_pkg::OFS_RX_STAT: s_next.rdata = {4'h0, s_reg.rxStat};
        hev_pkg::OFS_MODE: s_next.rdata = {5'h00, s_reg.mode};
        default: s_next.rdata = 8'h00; // command and unmapped read zero
      endcase
    end

    // level interrupt, low while any unmasked bit pends
    s_next.irqN = !((|(s_next.prim & ~s_next.mask[2:0])) ||
                    ((|s_next.ext) && !s_next.mask[hev_pkg::MASK_EXT]));
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  // synchronous reset, interrupt mode after reset
  // the synchroniser resets to the withdrawn level so no false edge follows
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.ctsSync <= 2'h3;
      s_reg.ctsPrev <= 1'b1;
      s_reg.mask <= hev_pkg::MASK_RESET;
      s_reg.mode <= hev_pkg::MODE_RESET;
      s_reg.dmaMode <= 1'b0;
      s_reg.txState <= hev_pkg::TX_IDLE;
      s_reg.irqN <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from flip-flops
  // no decoding after the registers, so the pins cannot glitch
  always_comb begin
    regRdata = s_reg.rdata;
    irqN = s_reg.irqN;
    txEom = s_reg.eom;
  end

endmodule // hev_event_sources

// ===== verification/hev_event_sources_monitor.sv
// property checker for the channel interrupt event sources
`timescale 1ns/1ps
module hev_event_sources_monitor (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdata,
  input wire logic rxFrameBegin,
  input wire logic rxFrameEnd,
  input wire logic rxFifoFull,
  input wire logic irqN,
  input wire logic txEom
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic [3:0] maskReg; // shadow of the mask register
  logic dmaReg; // shadow of the dma mode bit
  ////////////////////////////////////////////////////////////////
  // shadows let the properties know which events may reach irqN
  always_ff @(posedge mclk) begin
    if (rst) begin
      maskReg <= 4'h0;
      dmaReg <= 1'b0;
    end else if (regWrite) begin
      if (regAddr == hev_pkg::OFS_MASK) maskReg <= regWdata[3:0];
      if (regAddr == hev_pkg::OFS_CNT_HIGH) dmaReg <= regWdata[hev_pkg::CNTH_DMA];
    end
  end
  ////////////////////////////////////////////////////////////////
  sequence s_ovf;
    rxFrameBegin && rxFifoFull;
  endsequence
  sequence s_open;
    regWrite && regAddr == hev_pkg::OFS_COMMAND && regWdata[hev_pkg::CMD_TX_TRANSP];
  endsequence
  sequence s_eom;
    regWrite && regAddr == hev_pkg::OFS_COMMAND && regWdata[hev_pkg::CMD_TX_MSG_END] && !dmaReg
      && !regWdata[hev_pkg::CMD_TX_RESET];
  endsequence
  // overflow, three cycles without an extended read, then the read
  sequence s_ovf_read;
    s_ovf ##1 !(regRead && regAddr == hev_pkg::OFS_EXTENDED) [*3]
      ##1 (regRead && regAddr == hev_pkg::OFS_EXTENDED);
  endsequence
  a_rdata_idle: assert property (!regRead |=> regRdata == 8'h00)
    else $error("read data not zero outside read slot");
  a_ovf_irq: assert property (s_ovf ##0 !maskReg[3] |=> !irqN)
    else $error("overflow did not raise irq");
  a_ovf_read: assert property (s_ovf_read |=> regRdata[0])
    else $error("overflow bit missing on read");
  a_end_irq: assert property (rxFrameEnd && !dmaReg && !maskReg[1] |=> !irqN)
    else $error("message end did not raise irq");
  a_eom_cmd: assert property (s_eom |=> txEom)
    else $error("end of message command not seen");
  a_open_clear: assert property (s_open ##0 !regWdata[hev_pkg::CMD_TX_MSG_END] |=> !txEom)
    else $error("new frame kept an old end of message");
  a_irq_hold: assert property (!irqN && !regRead && !regWrite |=> !irqN)
    else $error("irq released without a read");
  a_irq_reset: assert property ($fell(rst) |-> irqN)
    else $error("irq active after reset");
  a_mask_all: assert property (regWrite && regAddr == hev_pkg::OFS_MASK && regWdata[3:0] == 4'hF
    |-> ##[1:2] irqN)
    else $error("irq not suppressed by full mask");
endmodule // hev_event_sources_monitor

// ===== verification/hev_line_model.sv
// receive line model: frames arriving from the far station
`timescale 1ns/1ps
module hev_line_model (
  input wire logic mclk,
  output logic rxFrameBegin,
  output logic rxOpenFlag,
  output logic rxByteStored,
  output logic rxFrameEnd
);
  initial {rxFrameBegin, rxOpenFlag, rxByteStored, rxFrameEnd} = 4'h0;
  ////////////////////////////////////////////////////////////////
  // opening flag, n stored bytes back to back, optional closing flag
  task automatic frame(input int n, input bit e);
    @(posedge mclk) {rxFrameBegin, rxOpenFlag} <= 2'b11;
    for (int i = 0; i < n; i++) begin
      @(posedge mclk) {rxFrameBegin, rxOpenFlag, rxByteStored} <= 3'b001;
    end
    @(posedge mclk) {rxFrameBegin, rxOpenFlag, rxByteStored, rxFrameEnd} <= {3'b000, e};
    @(posedge mclk) rxFrameEnd <= 1'b0;
  endtask
endmodule // hev_line_model

// ===== verification/tb.sv
// self-checking bench for the channel interrupt event sources
`timescale 1ns/1ps
module tb;
  logic mclk = 0, rst = 1, regWrite = 0, regRead = 0, rxFifoFull = 0, ctsN = 0;
  logic [3:0] regAddr = 4'h0, rxStatIn = 4'h5;
  logic [7:0] regWdata = 8'h00, rxCtrlIn = 8'h3C, rxAddrIn = 8'hA6;
  logic [8:0] ev = 9'h000; // tx, dma and address-match event pulses
  logic [7:0] regRdata;
  logic irqN, txEom, fb, of, bs, fe;
  int bad_count = 0, samples_checked = 0;
  hev_line_model line (.mclk(mclk), .rxFrameBegin(fb), .rxOpenFlag(of),
    .rxByteStored(bs), .rxFrameEnd(fe));
  hev_event_sources uut (.mclk(mclk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .rxByteStored(bs),
    .rxFrameBegin(fb), .rxFrameEnd(fe), .rxFifoFull(rxFifoFull), .rxAddrMatch(ev[8]),
    .rxOpenFlag(of), .dmaRxRead(ev[7]), .rxCtrlIn(rxCtrlIn), .rxAddrIn(rxAddrIn),
    .rxStatIn(rxStatIn), .txPoolFree(ev[0]), .txByteShifted(ev[1]), .txFrameDone(ev[2]),
    .txAllShifted(ev[3]), .txPosAck(ev[4]), .txNegAck(ev[5]), .txCollision(ev[6]),
    .ctsN(ctsN), .irqN(irqN), .txEom(txEom));
  initial forever #5 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk) {regWrite, regAddr, regWdata} <= {1'b1, a, d};
    @(posedge mclk) regWrite <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk) {regRead, regAddr} <= {1'b1, a};
    @(posedge mclk) regRead <= 1'b0;
    #1 chk(regRdata, exp);
  endtask
  task automatic pulse(input int i);
    @(posedge mclk) ev <= 9'h001 << i;
    @(posedge mclk) ev <= 9'h000;
  endtask
  task automatic irq(input logic e);
    @(posedge mclk);
    #1 chk({7'h00, irqN}, {7'h00, e});
  endtask
  task automatic conclude;
    $display("mismatches %0d of %0d checks", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    rd(4'h0, 8'h00);
    rd(4'h1, 8'h00);
    rd(4'h4, 8'h00);
    rd(4'hF, 8'h00);
    irq(1'b1);
    @(posedge mclk) rxFifoFull <= 1'b1;
    line.frame(0, 0);
    rxFifoFull <= 1'b0;
    irq(1'b0);
    rd(4'h1, 8'h01);
    irq(1'b1);
    line.frame(2, 0);
    rd(4'h1, 8'h00);
    wr(4'h3, 8'h01);
    line.frame(2, 0);
    rd(4'h1, 8'h02);
    rd(4'h7, 8'h3C);
    rd(4'h8, 8'hA6);
    rd(4'h9, 8'h05);
    line.frame(1, 1);
    rd(4'h0, 8'h02);
    line.frame(32, 0);
    rd(4'h0, 8'h01);
    rd(4'h1, 8'h02);
    wr(4'h2, 8'h0F);
    line.frame(0, 1);
    irq(1'b1);
    wr(4'h2, 8'h00);
    irq(1'b0);
    rd(4'h0, 8'h02);
    wr(4'h5, 8'h80);
    line.frame(3, 1);
    rd(4'h0, 8'h00);
    repeat (3) pulse(7);
    rd(4'h0, 8'h02);
    rd(4'h1, 8'h02);
    wr(4'h5, 8'h00);
    pulse(0);
    rd(4'h0, 8'h04);
    wr(4'h4, 8'h02);
    pulse(3);
    rd(4'h1, 8'h08);
    wr(4'h4, 8'h08);
    #1 chk({7'h00, txEom}, 8'h01);
    pulse(2);
    rd(4'h0, 8'h04);
    pulse(3);
    rd(4'h1, 8'h00);
    wr(4'hA, 8'h01);
    pulse(5);
    rd(4'h1, 8'h04);
    pulse(4);
    rd(4'h0, 8'h04);
    wr(4'hA, 8'h02);
    wr(4'h4, 8'h01);
    rd(4'h0, 8'h04);
    wr(4'h4, 8'h02);
    pulse(0);
    rd(4'h0, 8'h04);
    repeat (31) pulse(1);
    pulse(6);
    rd(4'h1, 8'h00);
    pulse(1);
    pulse(6);
    rd(4'h1, 8'h04);
    wr(4'hA, 8'h00);
    @(posedge mclk) ctsN <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(4'h1, 8'h04);
    wr(4'h4, 8'h01);
    wr(4'h6, 8'h03);
    wr(4'h5, 8'h80);
    wr(4'h4, 8'h02);
    repeat (2) pulse(1);
    wr(4'h4, 8'h08);
    #1 chk({7'h00, txEom}, 8'h00);
    pulse(1);
    #1 chk({7'h00, txEom}, 8'h01);
    wr(4'h5, 8'h00);
    wr(4'hA, 8'h04);
    line.frame(2, 0);
    rd(4'h1, 8'h00);
    pulse(8);
    line.frame(2, 0);
    rd(4'h1, 8'h02);
    conclude();
  end
endmodule // tb
bind hev_event_sources hev_event_sources_monitor mon (.mclk(mclk), .rst(rst),
  .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
  .regRdata(regRdata), .rxFrameBegin(rxFrameBegin), .rxFrameEnd(rxFrameEnd),
  .rxFifoFull(rxFifoFull), .irqN(irqN), .txEom(txEom));
